// >>> ufp_pkg.sv
package ufp_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NPORT = 3;
  localparam int unsigned NPIPE = 8;
  localparam int unsigned PIPE_W = 3;
  localparam int unsigned BUF_BYTES = 16;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned PTR_W = 5;
  localparam int unsigned TXN_W = 8;
  localparam int unsigned ENTRIES = NPIPE * BUF_BYTES;
  localparam int unsigned MADDR_W = PIPE_W + IDX_W;
  localparam logic [PTR_W-1:0] BUF_FULL = 5'h10;

  ////////////////////////////////////////////////////////////////
  localparam logic [ADDR_W-1:0] GEN_DATA_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] DMA0_DATA_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] DMA1_DATA_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] GEN_SEL_OFS = 8'h1E;
  localparam logic [ADDR_W-1:0] DMA0_SEL_OFS = 8'h24;
  localparam logic [ADDR_W-1:0] DMA1_SEL_OFS = 8'h2A;
  localparam logic [ADDR_W-1:0] DMA0_TXN_OFS = 8'h30;
  localparam logic [ADDR_W-1:0] DMA1_TXN_OFS = 8'h32;

  ////////////////////////////////////////////////////////////////
  localparam int unsigned READ_COUNT_MODE_BIT = 15;
  localparam int unsigned REW_BIT = 14;
  localparam int unsigned AUTO_CLEAR_MODE_BIT = 13;
  localparam int unsigned DMA_REQUEST_ENABLE_BIT = 12;
  localparam int unsigned MBW_BIT = 10;
  localparam int unsigned TXN_COUNTER_ENABLE_BIT = 9;
  localparam int unsigned TXN_COUNTER_CLEAR_BIT = 8;
  localparam int unsigned ZERO_LENGTH_APPEND_BIT = 7;
  localparam int unsigned CONTROL_PIPE_DIRECTION_BIT = 5;
  localparam int unsigned PIPE_LSB = 0;
  localparam logic [DATA_W-1:0] SEL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] SEL_DMA_MASK = 16'hB6A7;
  localparam logic [DATA_W-1:0] SEL_GEN_MASK = 16'h8427;

  ////////////////////////////////////////////////////////////////
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned DIR_SETUP_NS = 200;
  localparam int unsigned DIR_SETUP_CYC = (DIR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_W = 5;
  localparam logic [SETUP_W-1:0] SETUP_LOAD = SETUP_W'(DIR_SETUP_CYC - 1);

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_READ = 2'b01,
    OP_WRITE = 2'b10
  } ufp_op_t;
endpackage

// >>> ufp_buf_mem.sv
`timescale 1ns/1ps
module ufp_buf_mem (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic cpu_we_in,
  input wire logic cpu_wide_in,
  input wire logic [ufp_pkg::MADDR_W-1:0] cpu_addr_in,
  input wire logic [ufp_pkg::DATA_W-1:0] cpu_word_in,
  output logic [ufp_pkg::DATA_W-1:0] cpu_word_out,
  input wire logic se_we_in,
  input wire logic [ufp_pkg::MADDR_W-1:0] se_waddr_in,
  input wire logic [7:0] se_byte_in,
  input wire logic [ufp_pkg::MADDR_W-1:0] se_raddr_in,
  output logic [7:0] se_byte_out
);
  import ufp_pkg::*;

  logic [7:0] mem [ENTRIES];
  logic hi_ok;
  logic [MADDR_W-1:0] hi_addr;

  // the upper byte never spills into the next pipe's area
  assign hi_ok = cpu_addr_in[IDX_W-1:0] != {IDX_W{1'b1}};
  assign hi_addr = cpu_addr_in + 7'h01;
  assign cpu_word_out = {hi_ok ? mem[hi_addr] : 8'h00, mem[cpu_addr_in]};
  assign se_byte_out = mem[se_raddr_in];

  for (genvar e = 0; e < ENTRIES; e++) begin : g_entry
    localparam logic [MADDR_W-1:0] EA = MADDR_W'(e);
    always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
        mem[e] <= 8'h00;
      end else if (ce_in) begin
        if (cpu_we_in && cpu_addr_in == EA) begin
          mem[e] <= cpu_word_in[7:0];
        end else if (cpu_we_in && cpu_wide_in && hi_ok && hi_addr == EA) begin
          mem[e] <= cpu_word_in[15:8];
        end else if (se_we_in && se_waddr_in == EA) begin
          mem[e] <= se_byte_in;
        end
      end
    end
  end
endmodule

// >>> ufp_port_select.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
// Summary of operation
// - data register reads received bytes from, and writes transmit bytes to, the pipe buffer
// - control pipe buffer reachable only through the general port
// - dma requests exist only on the two dma ports
// - bit 15: 0 clears length when drained, 1 decrements per read
// - bit 14 write 1 rewinds the pointer; always reads 0
// - bit 13 set: buffer cleared automatically once its data is read
// - bit 12 gates the port's dma request output
// - bit 10 selects 8-bit or 16-bit port access
// - bit 9 enables the port's transaction counter
// - bit 8 write 1 clears the transaction count; reads 0
// - bit 7 set: a zero-length packet follows the transmit data
// - bit 5 gives direction while the control pipe is selected
// - bits 2-0 pick the pipe; 0 is the control pipe or none
// - direction bit set with pipe select or at least 200 ns later
// - dma port pipe code 0 means no pipe; keep pipe while request enabled
// - dma-only controls; clear and counter need receive, zero-length needs transmit
module ufp_port_select (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [ufp_pkg::ADDR_W-1:0] addr_in,
  input wire logic [ufp_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [ufp_pkg::DATA_W-1:0] rd_data_out,
  input wire logic [ufp_pkg::NPIPE-1:0] pipe_dir_in,
  input wire logic se_rx_valid_in,
  input wire logic [ufp_pkg::PIPE_W-1:0] se_rx_pipe_in,
  input wire logic [7:0] se_rx_byte_in,
  input wire logic [ufp_pkg::PIPE_W-1:0] se_rd_pipe_in,
  input wire logic [ufp_pkg::IDX_W-1:0] se_rd_idx_in,
  output logic [7:0] se_rd_byte_out,
  output logic [1:0] dma_request_out,
  output logic [1:0] zero_length_out,
  output logic [1:0] auto_clear_out
);
  import ufp_pkg::*;

  logic [DATA_W-1:0] sel [NPORT];
  logic [PTR_W-1:0] ptr [NPORT];
  logic [PTR_W-1:0] len [NPIPE];
  logic [TXN_W-1:0] txn [2];
  logic [SETUP_W-1:0] settle;
  logic sel_hit;
  logic data_hit;
  logic txn_hit;
  logic [1:0] acc_port;
  logic txn_port;
  logic [DATA_W-1:0] cur_sel;
  logic [PIPE_W-1:0] cur_pipe;
  logic is_dma;
  logic cur_tx;
  logic pipe_ok;
  ufp_op_t op;
  logic [PTR_W-1:0] step;
  logic [PTR_W-1:0] cur_ptr;
  logic [PTR_W:0] ptr_sum;
  logic [PTR_W-1:0] next_ptr;
  logic [PTR_W-1:0] cur_len;
  logic [PTR_W-1:0] new_len;
  logic [PTR_W-1:0] wr_len;
  logic drained;
  logic auto_clr;
  logic se_ok;
  logic control_pipe_direction_ok;
  logic [DATA_W-1:0] next_sel;
  logic [DATA_W-1:0] mem_word;
  logic [DATA_W-1:0] next_rd;
  logic [7:0] se_rd_byte_out_c;

  ////////////////////////////////////////////////////////////////
  // address decode
  always_comb begin
    sel_hit = 1'b0;
    data_hit = 1'b0;
    txn_hit = 1'b0;
    acc_port = 2'd0;
    txn_port = 1'b0;
    if (addr_in == GEN_SEL_OFS) begin
      sel_hit = 1'b1;
    end else if (addr_in == DMA0_SEL_OFS) begin
      sel_hit = 1'b1;
      acc_port = 2'd1;
    end else if (addr_in == DMA1_SEL_OFS) begin
      sel_hit = 1'b1;
      acc_port = 2'd2;
    end else if (addr_in == GEN_DATA_OFS) begin
      data_hit = 1'b1;
    end else if (addr_in == DMA0_DATA_OFS) begin
      data_hit = 1'b1;
      acc_port = 2'd1;
    end else if (addr_in == DMA1_DATA_OFS) begin
      data_hit = 1'b1;
      acc_port = 2'd2;
    end else if (addr_in == DMA0_TXN_OFS) begin
      txn_hit = 1'b1;
    end else if (addr_in == DMA1_TXN_OFS) begin
      txn_hit = 1'b1;
      txn_port = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // access of the addressed port
  assign cur_sel = sel[acc_port];
  assign cur_pipe = cur_sel[PIPE_LSB +: PIPE_W];
  assign is_dma = acc_port != 2'd0;
  // control pipe direction comes from the select register, others from pipe config
  assign cur_tx = (cur_pipe == 3'h0) ? cur_sel[CONTROL_PIPE_DIRECTION_BIT] : pipe_dir_in[cur_pipe];
  // pipe 0 on a dma port is no pipe, so the control pipe stays general-only
  assign pipe_ok = !(is_dma && cur_pipe == 3'h0);

  always_comb begin
    op = OP_NONE;
    if (data_hit && pipe_ok && rd_in && !cur_tx) begin
      op = OP_READ;
    end else if (data_hit && pipe_ok && wr_in && cur_tx) begin
      op = OP_WRITE;
    end
  end

  assign step = cur_sel[MBW_BIT] ? 5'h02 : 5'h01;
  assign cur_ptr = ptr[acc_port];
  assign ptr_sum = {1'b0, cur_ptr} + {1'b0, step};
  // pointer saturates at the end; a wide access at the last byte moves one
  assign next_ptr = (ptr_sum > {1'b0, BUF_FULL}) ? BUF_FULL : ptr_sum[PTR_W-1:0];
  assign cur_len = len[cur_pipe];
  assign wr_len = (next_ptr > cur_len) ? next_ptr : cur_len;

  always_comb begin
    new_len = cur_len;
    if (cur_sel[READ_COUNT_MODE_BIT]) begin
      new_len = (cur_len > step) ? cur_len - step : 5'h00;
    end else if (next_ptr >= cur_len) begin
      new_len = 5'h00;
    end
  end

  assign drained = (op == OP_READ) && (new_len == 5'h00);
  assign auto_clr = drained && is_dma && cur_sel[AUTO_CLEAR_MODE_BIT];

  // a cpu access to the same pipe wins; the engine byte is dropped
  assign se_ok = se_rx_valid_in && (len[se_rx_pipe_in] < BUF_FULL)
    && !(op != OP_NONE && cur_pipe == se_rx_pipe_in);

  ////////////////////////////////////////////////////////////////
  // buffer memory
  ufp_buf_mem ufp_buf_mem_inst (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .cpu_we_in(op == OP_WRITE),
    .cpu_wide_in(cur_sel[MBW_BIT]),
    .cpu_addr_in({cur_pipe, cur_ptr[IDX_W-1:0]}),
    .cpu_word_in(wr_data_in),
    .cpu_word_out(mem_word),
    .se_we_in(se_ok),
    .se_waddr_in({se_rx_pipe_in, len[se_rx_pipe_in][IDX_W-1:0]}),
    .se_byte_in(se_rx_byte_in),
    .se_raddr_in({se_rd_pipe_in, se_rd_idx_in}),
    .se_byte_out(se_rd_byte_out_c)
  );

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      se_rd_byte_out <= 8'h00;
    end else if (ce_in) begin
      se_rd_byte_out <= se_rd_byte_out_c;
    end
  end

  ////////////////////////////////////////////////////////////////
  // select registers; strobe bits are never stored so they read 0
  always_comb begin
    control_pipe_direction_ok = 1'b1;
    next_sel = wr_data_in & SEL_DMA_MASK;
    if (!is_dma) begin
      next_sel = wr_data_in & SEL_GEN_MASK;
      // direction alone is refused until the pipe change has settled
      control_pipe_direction_ok = (settle == 5'h00) || (wr_data_in[PIPE_W-1:0] != cur_pipe);
      if (!control_pipe_direction_ok) begin
        next_sel[CONTROL_PIPE_DIRECTION_BIT] = cur_sel[CONTROL_PIPE_DIRECTION_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      for (int p = 0; p < NPORT; p++) begin
        sel[p] <= SEL_RESET;
      end
    end else if (ce_in && sel_hit && wr_in) begin
      sel[acc_port] <= next_sel;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      settle <= 5'h00;
    end else if (ce_in) begin
      if (sel_hit && wr_in && !is_dma && wr_data_in[PIPE_W-1:0] != cur_pipe) begin
        settle <= SETUP_LOAD;
      end else if (settle != 5'h00) begin
        settle <= settle - 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // buffer pointers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      for (int p = 0; p < NPORT; p++) begin
        ptr[p] <= 5'h00;
      end
    end else if (ce_in) begin
      if (sel_hit && wr_in) begin
        if (wr_data_in[REW_BIT] || wr_data_in[PIPE_W-1:0] != cur_pipe) begin
          ptr[acc_port] <= 5'h00;
        end
      end else if (auto_clr) begin
        ptr[acc_port] <= 5'h00;
      end else if (op != OP_NONE) begin
        ptr[acc_port] <= next_ptr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // per-pipe data length
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      for (int q = 0; q < NPIPE; q++) begin
        len[q] <= 5'h00;
      end
    end else if (ce_in) begin
      if (se_ok) begin
        len[se_rx_pipe_in] <= len[se_rx_pipe_in] + 5'h01;
      end
      if (op == OP_READ) begin
        len[cur_pipe] <= new_len;
      end else if (op == OP_WRITE) begin
        len[cur_pipe] <= wr_len;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // register read, data valid only in the cycle after the strobe
  always_comb begin
    next_rd = 16'h0000;
    if (sel_hit) begin
      next_rd = cur_sel;
    end else if (op == OP_READ) begin
      next_rd = cur_sel[MBW_BIT] ? mem_word : {8'h00, mem_word[7:0]};
    end else if (txn_hit) begin
      next_rd = {8'h00, txn[txn_port]};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rd_data_out <= 16'h0000;
    end else if (ce_in) begin
      rd_data_out <= rd_in ? next_rd : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////
  // dma port services
  for (genvar k = 0; k < 2; k++) begin : g_dma
    localparam logic [1:0] PIDX = 2'(k + 1);
    logic [PIPE_W-1:0] kpipe;
    logic ktx;
    assign kpipe = sel[PIDX][PIPE_W-1:0];
    assign ktx = pipe_dir_in[kpipe];

    always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
        dma_request_out[k] <= 1'b0;
        zero_length_out[k] <= 1'b0;
        auto_clear_out[k] <= 1'b0;
      end else if (ce_in) begin
        // requests only for a real pipe with room or data
        dma_request_out[k] <= sel[PIDX][DMA_REQUEST_ENABLE_BIT] && kpipe != 3'h0
          && (ktx ? ptr[PIDX] < BUF_FULL : len[kpipe] != 5'h00);
        // transmit buffer filled: mark that a zero-length packet follows
        zero_length_out[k] <= op == OP_WRITE && acc_port == PIDX
          && sel[PIDX][ZERO_LENGTH_APPEND_BIT] && next_ptr == BUF_FULL;
        auto_clear_out[k] <= auto_clr && acc_port == PIDX;
      end
    end

    always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
        txn[k] <= 8'h00;
      end else if (ce_in) begin
        if (sel_hit && wr_in && acc_port == PIDX && wr_data_in[TXN_COUNTER_CLEAR_BIT]) begin
          txn[k] <= 8'h00;
        end else if (drained && acc_port == PIDX && sel[PIDX][TXN_COUNTER_ENABLE_BIT]) begin
          txn[k] <= txn[k] + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  a_rewind_to_start: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && wr_in && addr_in == DMA0_SEL_OFS && wr_data_in[REW_BIT] |=> ptr[1] == 5'h00)
    else $error("pointer not rewound");

  a_strobe_bits_zero: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && rd_in && sel_hit |=> !rd_data_out[REW_BIT] && !rd_data_out[TXN_COUNTER_CLEAR_BIT])
    else $error("strobe bit reads back set");

  a_dma_request_out_gated: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    $past(ce_in) && !$past(sel[1][DMA_REQUEST_ENABLE_BIT]) |-> !dma_request_out[0])
    else $error("request while disabled");

  a_dma_pipe_none: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && rd_in && addr_in == DMA0_DATA_OFS && sel[1][PIPE_W-1:0] == 3'h0
    |=> ptr[1] == $past(ptr[1]))
    else $error("pointer moved with no pipe");

  a_byte_step: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && op == OP_READ && acc_port == 2'd1 && !sel[1][MBW_BIT] && ptr[1] < BUF_FULL && !auto_clr
    |=> ptr[1] == $past(ptr[1]) + 5'h01)
    else $error("byte access step wrong");

  a_word_step: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && op == OP_WRITE && acc_port == 2'd1 && sel[1][MBW_BIT] && ptr[1] < 5'h0F
    |=> ptr[1] == $past(ptr[1]) + 5'h02)
    else $error("word access step wrong");

  a_count_decrement: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && op == OP_READ && cur_sel[READ_COUNT_MODE_BIT] && cur_len > step
    |=> len[$past(cur_pipe)] == $past(cur_len) - $past(step))
    else $error("length not decremented");

  a_txn_clear: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    ce_in && wr_in && addr_in == DMA1_SEL_OFS && wr_data_in[TXN_COUNTER_CLEAR_BIT] |=> txn[1] == 8'h00)
    else $error("count not cleared");

  a_zero_len_cause: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    zero_length_out[0] |-> $past(op == OP_WRITE && acc_port == 2'd1 && sel[1][ZERO_LENGTH_APPEND_BIT]))
    else $error("zero-length mark without cause");

  a_control_general: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    op != OP_NONE && cur_pipe == 3'h0 |-> acc_port == 2'd0)
    else $error("control pipe reached by dma port");
endmodule

// >>> ufp_se_model.sv
`timescale 1ns/1ps
module ufp_se_model (
  input wire logic clk_sys_in,
  output logic se_rx_valid_out,
  output logic [ufp_pkg::PIPE_W-1:0] se_rx_pipe_out,
  output logic [7:0] se_rx_byte_out,
  output logic [ufp_pkg::PIPE_W-1:0] se_rd_pipe_out,
  output logic [ufp_pkg::IDX_W-1:0] se_rd_idx_out,
  input wire logic [7:0] se_rd_byte_in
);
  import ufp_pkg::*;

  initial begin
    se_rx_valid_out = 1'h0;
    se_rx_pipe_out = 3'h0;
    se_rx_byte_out = 8'h00;
    se_rd_pipe_out = 3'h0;
    se_rd_idx_out = 4'h0;
  end

  ////////////////////////////////////////////////////////////////
  // one received byte per call; idle byte shows the inverse so a stale value never passes
  task automatic push(input logic [PIPE_W-1:0] p, input logic [7:0] b);
    @(posedge clk_sys_in);
    se_rx_valid_out <= 1'h1;
    se_rx_pipe_out <= p;
    se_rx_byte_out <= b;
    @(posedge clk_sys_in);
    se_rx_valid_out <= 1'h0;
    se_rx_byte_out <= ~b;
  endtask

  ////////////////////////////////////////////////////////////////
  // transmit byte fetch, answer one cycle after the address is taken
  task automatic fetch(input logic [PIPE_W-1:0] p, input logic [IDX_W-1:0] i, output logic [7:0] b);
    @(posedge clk_sys_in);
    se_rd_pipe_out <= p;
    se_rd_idx_out <= i;
    @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    #1 b = se_rd_byte_in;
  endtask
endmodule

// >>> ufp_port_select_bench.sv
`timescale 1ns/1ps
module ufp_port_select_bench;
  import ufp_pkg::*;
  logic clk_sys_in = 1'h0;
  logic rst_in = 1'h1;
  logic ce_in = 1'h1;
  logic [ADDR_W-1:0] addr_in = 8'h00;
  logic [DATA_W-1:0] wr_data_in = 16'h0000;
  logic wr_in = 1'h0;
  logic rd_in = 1'h0;
  logic [DATA_W-1:0] rd_data_out;
  logic [NPIPE-1:0] pipe_dir_in = 8'h10;
  logic se_rx_valid_in;
  logic [PIPE_W-1:0] se_rx_pipe_in;
  logic [7:0] se_rx_byte_in;
  logic [PIPE_W-1:0] se_rd_pipe_in;
  logic [IDX_W-1:0] se_rd_idx_in;
  logic [7:0] se_rd_byte_out;
  logic [1:0] dma_request_out;
  logic [1:0] zero_length_out;
  logic [1:0] auto_clear_out;
  int err_total = 0;
  int num_checks = 0;
  int seed = 70;
  int cycles = 0;
  int k;
  logic [17:0] exp_q[$];
  logic rd_seen = 1'h0;
  logic [7:0] rx[4];
  logic [7:0] b0;
  logic [7:0] b1;
  logic [15:0] w;
  logic [15:0] v;

  always #5 clk_sys_in = ~clk_sys_in;

  ufp_port_select ufp_port_select_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .pipe_dir_in(pipe_dir_in), .se_rx_valid_in(se_rx_valid_in), .se_rx_pipe_in(se_rx_pipe_in),
    .se_rx_byte_in(se_rx_byte_in), .se_rd_pipe_in(se_rd_pipe_in), .se_rd_idx_in(se_rd_idx_in),
    .se_rd_byte_out(se_rd_byte_out), .dma_request_out(dma_request_out),
    .zero_length_out(zero_length_out), .auto_clear_out(auto_clear_out));

  ufp_se_model se_model_inst (.clk_sys_in(clk_sys_in), .se_rx_valid_out(se_rx_valid_in),
    .se_rx_pipe_out(se_rx_pipe_in), .se_rx_byte_out(se_rx_byte_in), .se_rd_pipe_out(se_rd_pipe_in),
    .se_rd_idx_out(se_rd_idx_in), .se_rd_byte_in(se_rd_byte_out));

  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys_in);
    wr_in <= 1'h1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_sys_in);
    wr_in <= 1'h0;
  endtask

  // expected data and auto clear pulse are noted here, compared by the monitor
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] ac = 2'h0);
    @(posedge clk_sys_in);
    rd_in <= 1'h1;
    addr_in <= a;
    exp_q.push_back({ac, d});
    @(posedge clk_sys_in);
    rd_in <= 1'h0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_in) begin
    if (rd_seen && exp_q.size() > 0) begin
      check("read data", exp_q.pop_front(), {auto_clear_out, rd_data_out});
    end
    rd_seen <= rd_in;
  end

  // generous ceiling; the sequence needs well under a thousand cycles
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    rd(GEN_SEL_OFS, 16'h0000);
    rd(DMA0_SEL_OFS, 16'h0000);
    rd(DMA1_SEL_OFS, 16'h0000);
    rd(8'h02, 16'h0000);
    // reserved bits 11, 6, 4, 3 always written 0
    wr(DMA0_SEL_OFS, 16'hE7A7);
    rd(DMA0_SEL_OFS, 16'hA6A7);
    wr(GEN_SEL_OFS, 16'hF7A6);
    rd(GEN_SEL_OFS, 16'h8426);
    settle(3);
    check("dma request", 18'h0, dma_request_out);
    wr(DMA0_SEL_OFS, 16'h0000);
    wr(GEN_SEL_OFS, 16'h0000);
    for (int p = 0; p < 8; p++) begin
      v = (16'($random(seed)) & 16'hE7A0) | {13'h0000, 3'(p)};
      wr(DMA1_SEL_OFS, v);
      rd(DMA1_SEL_OFS, v & SEL_DMA_MASK);
    end
    wr(DMA1_SEL_OFS, 16'h0000);
    // receive, count mode 0, 16-bit, auto clear and counter on dma0
    for (int i = 0; i < 4; i++) begin
      rx[i] = 8'($random(seed));
      se_model_inst.push(3'h2, rx[i]);
    end
    wr(DMA0_SEL_OFS, 16'h3602);
    settle(3);
    check("dma request", 18'h1, dma_request_out);
    rd(DMA0_DATA_OFS, {rx[1], rx[0]});
    wr(DMA0_SEL_OFS, 16'h7602);
    rd(DMA0_DATA_OFS, {rx[1], rx[0]});
    settle(3);
    check("dma request", 18'h1, dma_request_out);
    rd(DMA0_DATA_OFS, {rx[3], rx[2]}, 2'h1);
    settle(3);
    check("dma request", 18'h0, dma_request_out);
    rd(DMA0_TXN_OFS, 16'h0001);
    wr(DMA0_SEL_OFS, 16'h3702);
    rd(DMA0_TXN_OFS, 16'h0000);
    // enable dropped before the pipe moves
    wr(DMA0_SEL_OFS, 16'h0002);
    wr(DMA0_SEL_OFS, 16'h0000);
    // receive, count mode 1, 8-bit on dma1
    for (int i = 0; i < 3; i++) begin
      rx[i] = 8'($random(seed));
      se_model_inst.push(3'h3, rx[i]);
    end
    wr(DMA1_SEL_OFS, 16'h9003);
    rd(DMA1_DATA_OFS, {8'h00, rx[0]});
    // width left alone while the buffer is still being read
    wr(DMA1_SEL_OFS, 16'hD003);
    rd(DMA1_DATA_OFS, {8'h00, rx[0]});
    rd(DMA1_DATA_OFS, {8'h00, rx[1]});
    settle(3);
    check("dma request", 18'h0, dma_request_out);
    wr(DMA1_SEL_OFS, 16'h0003);
    wr(DMA1_SEL_OFS, 16'h0000);
    // dma port with code 0 selects nothing
    wr(DMA0_SEL_OFS, 16'h1400);
    rd(DMA0_DATA_OFS, 16'h0000);
    settle(3);
    check("dma request", 18'h0, dma_request_out);
    wr(DMA0_SEL_OFS, 16'h0000);
    // control pipe through the general port
    wr(GEN_SEL_OFS, 16'h0001);
    wr(GEN_SEL_OFS, 16'h0420);
    w = 16'($random(seed));
    wr(GEN_DATA_OFS, w);
    wr(GEN_SEL_OFS, 16'h0400);
    rd(GEN_SEL_OFS, 16'h0420);
    se_model_inst.fetch(3'h0, 4'h0, b0);
    se_model_inst.fetch(3'h0, 4'h1, b1);
    check("control buffer", {2'h0, w}, {2'h0, b1, b0});
    repeat (DIR_SETUP_CYC) @(posedge clk_sys_in);
    wr(GEN_SEL_OFS, 16'h0400);
    rd(GEN_SEL_OFS, 16'h0400);
    wr(GEN_SEL_OFS, 16'h0401);
    wr(GEN_SEL_OFS, 16'h0400);
    rd(GEN_DATA_OFS, w);
    wr(GEN_SEL_OFS, 16'h0001);
    // transmit pipe 4 with zero-length mark on dma0
    wr(DMA0_SEL_OFS, 16'h1484);
    settle(3);
    check("dma request", 18'h1, dma_request_out);
    for (int i = 0; i < 8; i++) begin
      wr(DMA0_DATA_OFS, 16'($random(seed)));
    end
    #1;
    k = 0;
    while (zero_length_out !== 2'h1 && k < 4) begin
      @(posedge clk_sys_in);
      #1 k++;
    end
    check("zero length", 18'h1, zero_length_out);
    settle(3);
    check("dma request", 18'h0, dma_request_out);
    rd(DMA0_DATA_OFS, 16'h0000);
    settle(3);
    // mid-run reset puts the selects back to their reset value
    @(posedge clk_sys_in);
    rst_in <= 1'h1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    rd(DMA0_SEL_OFS, SEL_RESET);
    // a write while the clock enable is low must leave no trace
    @(posedge clk_sys_in);
    ce_in <= 1'h0;
    wr(DMA1_SEL_OFS, 16'h0005);
    ce_in <= 1'h1;
    rd(DMA1_SEL_OFS, SEL_RESET);
    // byte-wide receive on dma0
    rx[0] = 8'($random(seed));
    se_model_inst.push(3'h5, rx[0]);
    wr(DMA0_SEL_OFS, 16'h0005);
    rd(DMA0_DATA_OFS, {8'h00, rx[0]});
    settle(3);
    wrap_up();
  end
endmodule
